// File: src/bonding_deskew_params.svh
// Purpose: constants for the bonded channel deskew block
// Assumes: one EQ is 72 bits, two 36-bit link transfers
// Notes:   header field positions are within the 64 data bits of an EQ
`ifndef BONDING_DESKEW_PARAMS_SVH
`define BONDING_DESKEW_PARAMS_SVH

`define NUM_ROWS       32
`define ROW_W          5
`define NUM_COLS       4
`define COL_W          2
`define EQ_W           72
`define EQ_DATA_W      64
`define EQ_CTRL_W      8
`define XFER_DATA_W    32
`define XFER_CTRL_W    4
`define LOGICAL_LINK_IDENTIFIER_W         16
`define LEN_W          16
`define MAC_W          2
`define CFG_W          4

// header layout inside eq data
`define HDR_START_LSB  0
`define HDR_START_MSB  7
`define HDR_SF_BIT     8
`define HDR_ROW_LSB    9
`define HDR_ROW_MSB    13
`define HDR_LOGICAL_LINK_IDENTIFIER_LSB   32
`define HDR_LOGICAL_LINK_IDENTIFIER_MSB   47
`define HDR_LEN_LSB    48
`define HDR_LEN_MSB    63

`define START_CODE     8'hFB
`define HDR_CTRL       8'h01
`define DATA_CTRL      8'h00
`define IDLE_CTRL      8'hFF
`define IDLE_DATA      64'h0707070707070707

// pointer spacing and delay bound, in rows (one row per eq period)
`define TX_LAG         5'h01
`define RX_LAG         5'h10
`define DELAY_BOUND_EQ 5'h18

// configuration encodings: 0 = one, 1 = two, 2 = four
`define MODE_ONE       2'h0
`define MODE_TWO       2'h1
`define MASK_ONE       2'h0
`define MASK_TWO       2'h1
`define MASK_FOUR      2'h3
`define COL_LAST       2'h3

// link clock
`define LINK_CLK_MHZ   390.625

`endif

// File: src/bonding_deskew_pkg.sv
// Purpose: types shared by the bonded channel deskew block
// Assumes: constants come from the params header
// Notes:   all carriers are packed structs
`include "bonding_deskew_params.svh"

package bonding_deskew_pkg;

    typedef struct packed {
        logic [`EQ_CTRL_W-1:0] ctrl;
        logic [`EQ_DATA_W-1:0] data;
    } eq_t;

    // item handed from the mac side to the link side
    typedef struct packed {
        logic                is_env;
        logic [`COL_W-1:0]   ch;
        logic [`LOGICAL_LINK_IDENTIFIER_W-1:0]  logical_link_identifier;
        logic [`LEN_W-1:0]   len;
        eq_t                 eq;
    } tx_item_t;

    // item handed from the link side to the mac side
    typedef struct packed {
        logic [`MAC_W-1:0]   mac;
        logic                cont_hdr;
        eq_t                 eq;
    } rx_item_t;

    typedef struct packed {
        logic                act;
        logic                hdr;
        logic [`LOGICAL_LINK_IDENTIFIER_W-1:0]  logical_link_identifier;
        logic [`LEN_W-1:0]   rem;
    } tx_chan_t;

    typedef struct packed {
        logic                vld;
        logic                start;
        logic                cont;
        logic [`MAC_W-1:0]   mac;
        eq_t                 eq;
    } rx_cell_t;

    typedef enum logic [1:0] {
        RX_HUNT  = 2'b00,
        RX_HDR2  = 2'b01,
        RX_BODY1 = 2'b10,
        RX_BODY2 = 2'b11
    } rx_state_t;

endpackage

// File: src/bonding_deskew.sv
// Purpose: bonded channel transmit/receive with row aligned deskew buffers
// Assumes: mac side on core_clk_i, all link logic on link_clk_i
// Notes:   one quantum crosses per handshake in each direction
`timescale 1ns/10ps
`include "bonding_deskew_params.svh"

module level_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    wire          agree = (s2_r == s3_r);

    // change counts once second and third stages agree
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q_o  <= '0;
        end else begin
            s1_r <= d_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (agree) begin
                q_o <= s3_r;
            end
        end
    end
endmodule // level_sync

module bonding_deskew
    import bonding_deskew_pkg::*;
(
    // clocks and reset
    input  wire logic                    core_clk_i,
    input  wire logic                    link_clk_i,
    input  wire logic                    rst_i,
    // configuration
    input  wire logic [1:0]              cfg_ch_mode_i,
    input  wire logic [1:0]              cfg_mac_mode_i,
    // mac side transmit
    input  wire logic                    tx_valid_i,
    input  wire tx_item_t                tx_item_i,
    output logic                         tx_ready_o,
    // mac side receive
    output logic                         rx_valid_o,
    output rx_item_t                     rx_item_o,
    // link transmit
    output logic [`XFER_DATA_W-1:0]      txd_o [`NUM_COLS],
    output logic [`XFER_CTRL_W-1:0]      txc_o [`NUM_COLS],
    // link receive
    input  wire logic [`XFER_DATA_W-1:0] rxd_i [`NUM_COLS],
    input  wire logic [`XFER_CTRL_W-1:0] rxc_i [`NUM_COLS],
    // status
    output logic                         delay_fault_o
);

    // ---------------- mac side (core clock) ----------------
    logic     tx_req_r;
    tx_item_t tx_hold_r;
    logic     tx_ack_s;
    logic     out_req_s;
    logic     out_ack_r;
    rx_item_t out_item_r;
    logic     out_req_r;
    logic     tx_seen_r;
    wire      tx_take    = tx_valid_i && tx_ready_o;
    wire      tx_idle    = (tx_req_r == tx_ack_s);
    wire      out_new    = (out_req_s != out_ack_r);

    level_sync #(.W(1)) u_tx_ack_sync (
        .clk_i (core_clk_i),
        .rst_i (rst_i),
        .d_i   (tx_seen_r),
        .q_o   (tx_ack_s)
    );
    level_sync #(.W(1)) u_out_req_sync (
        .clk_i (core_clk_i),
        .rst_i (rst_i),
        .d_i   (out_req_r),
        .q_o   (out_req_s)
    );

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_req_r   <= 1'b0;
            tx_hold_r  <= '0;
            tx_ready_o <= 1'b0;
        end else begin
            tx_ready_o <= !tx_take && tx_idle;
            if (tx_take) begin
                tx_hold_r <= tx_item_i;
                tx_req_r  <= !tx_req_r;
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            out_ack_r  <= 1'b0;
            rx_valid_o <= 1'b0;
            rx_item_o  <= '0;
        end else begin
            rx_valid_o <= out_new;
            if (out_new) begin
                rx_item_o <= out_item_r;
                out_ack_r <= out_req_s;
            end
        end
    end

    // ---------------- link side (link clock) ----------------
    logic [`CFG_W-1:0] cfg_s;
    logic              tx_req_s;
    logic              out_ack_s;

    level_sync #(.W(`CFG_W)) u_cfg_sync (
        .clk_i (link_clk_i),
        .rst_i (rst_i),
        .d_i   ({cfg_mac_mode_i, cfg_ch_mode_i}),
        .q_o   (cfg_s)
    );
    level_sync #(.W(1)) u_tx_req_sync (
        .clk_i (link_clk_i),
        .rst_i (rst_i),
        .d_i   (tx_req_r),
        .q_o   (tx_req_s)
    );
    level_sync #(.W(1)) u_out_ack_sync (
        .clk_i (link_clk_i),
        .rst_i (rst_i),
        .d_i   (out_ack_r),
        .q_o   (out_ack_s)
    );

    // enabled columns and mac mask from the channel/mac modes
    wire [`NUM_COLS-1:0] col_en   = (cfg_s[1:0] == `MODE_ONE) ? 4'h1 :
                                    (cfg_s[1:0] == `MODE_TWO) ? 4'h3 : 4'hF;
    wire [`MAC_W-1:0]    mac_mask = (cfg_s[3:2] == `MODE_ONE) ? `MASK_ONE :
                                    (cfg_s[3:2] == `MODE_TWO) ? `MASK_TWO : `MASK_FOUR;

    // ---- transmit ----
    eq_t         tx_buf [`NUM_ROWS][`NUM_COLS];
    tx_chan_t    chan_r [`NUM_COLS];
    logic        phase_r;
    logic [`ROW_W-1:0] tx_wr_r;
    logic [`COL_W-1:0] last_col_r;
    logic        stage_v_r;
    tx_item_t    stage_r;
    wire [`ROW_W-1:0]  tx_rd      = tx_wr_r - `TX_LAG;
    wire         tx_new     = (tx_req_s != tx_seen_r);
    wire         tx_accept  = tx_new && !phase_r &&
                              (tx_hold_r.is_env ? !chan_r[tx_hold_r.ch].act : !stage_v_r);
    wire         row_done   = phase_r;

    eq_t               row_eq [`NUM_COLS];
    logic              pick_v;
    logic [`COL_W-1:0] pick_c;

    always_comb begin
        logic [`COL_W-1:0] c;
        c      = '0;
        pick_v = 1'b0;
        pick_c = '0;
        // next matching column after the last one used, ascending with wrap
        for (int k = 1; k <= `NUM_COLS; k++) begin
            c = last_col_r + k[`COL_W-1:0];
            if (!pick_v && stage_v_r && col_en[c] && chan_r[c].act && !chan_r[c].hdr &&
                chan_r[c].logical_link_identifier == stage_r.logical_link_identifier) begin
                pick_v = 1'b1;
                pick_c = c;
            end
        end
        for (int j = 0; j < `NUM_COLS; j++) begin
            row_eq[j].ctrl = `IDLE_CTRL;
            row_eq[j].data = `IDLE_DATA;
            if (col_en[j] && chan_r[j].act && chan_r[j].hdr) begin
                row_eq[j].ctrl = `HDR_CTRL;
                row_eq[j].data = '0;
                row_eq[j].data[`HDR_START_MSB:`HDR_START_LSB] = `START_CODE;
                row_eq[j].data[`HDR_SF_BIT]                   = 1'b1;
                row_eq[j].data[`HDR_ROW_MSB:`HDR_ROW_LSB]     = tx_wr_r;
                row_eq[j].data[`HDR_LOGICAL_LINK_IDENTIFIER_MSB:`HDR_LOGICAL_LINK_IDENTIFIER_LSB]   = chan_r[j].logical_link_identifier;
                row_eq[j].data[`HDR_LEN_MSB:`HDR_LEN_LSB]     = chan_r[j].rem;
            end else if (pick_v && pick_c == j[`COL_W-1:0]) begin
                row_eq[j] = stage_r.eq;
            end
        end
    end

    always_ff @(posedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase_r    <= 1'b0;
            tx_wr_r    <= '0;
            last_col_r <= `COL_LAST;
            stage_v_r  <= 1'b0;
            stage_r    <= '0;
            tx_seen_r  <= 1'b0;
            for (int j = 0; j < `NUM_COLS; j++) begin
                chan_r[j] <= '0;
                txd_o[j]  <= '0;
                txc_o[j]  <= '0;
            end
        end else begin
            phase_r <= !phase_r;
            // every column of one row written together, then the row advances
            if (row_done) begin
                for (int j = 0; j < `NUM_COLS; j++) begin
                    tx_buf[tx_wr_r][j] <= row_eq[j];
                    if (chan_r[j].act && (chan_r[j].hdr || (pick_v && pick_c == j[`COL_W-1:0]))) begin
                        chan_r[j].hdr <= 1'b0;
                        chan_r[j].rem <= chan_r[j].rem - 1'b1;
                        chan_r[j].act <= (chan_r[j].rem != 16'h0001);
                    end
                end
                tx_wr_r <= tx_wr_r + 1'b1;
                if (pick_v) begin
                    last_col_r <= pick_c;
                    stage_v_r  <= 1'b0;
                end
            end
            if (tx_accept) begin
                tx_seen_r <= tx_req_s;
                if (tx_hold_r.is_env) begin
                    chan_r[tx_hold_r.ch] <= '{act: (tx_hold_r.len != '0), hdr: 1'b1,
                                              logical_link_identifier: tx_hold_r.logical_link_identifier, rem: tx_hold_r.len};
                end else begin
                    stage_v_r <= 1'b1;
                    stage_r   <= tx_hold_r;
                end
            end
            // one quantum as two transfers, all columns on one clock
            for (int j = 0; j < `NUM_COLS; j++) begin
                txd_o[j] <= phase_r ? tx_buf[tx_rd][j].data[`EQ_DATA_W-1:`XFER_DATA_W]
                                    : tx_buf[tx_rd][j].data[`XFER_DATA_W-1:0];
                txc_o[j] <= phase_r ? tx_buf[tx_rd][j].ctrl[`EQ_CTRL_W-1:`XFER_CTRL_W]
                                    : tx_buf[tx_rd][j].ctrl[`XFER_CTRL_W-1:0];
            end
        end
    end

    // ---- receive ----
    rx_cell_t          rx_buf [`NUM_ROWS][`NUM_COLS];
    rx_state_t         rx_st_r  [`NUM_COLS];
    logic [`XFER_DATA_W-1:0] lo_d_r [`NUM_COLS];
    logic [`XFER_CTRL_W-1:0] lo_c_r [`NUM_COLS];
    logic [`ROW_W-1:0] rx_wr_r  [`NUM_COLS];
    logic [`LEN_W-1:0] rx_rem_r [`NUM_COLS];
    logic [`MAC_W-1:0] rx_mac_r [`NUM_COLS];
    logic [`ROW_W-1:0] rx_rd_r;
    logic [`COL_W-1:0] rx_col_r;
    logic              lock_r;
    logic              out_busy;
    eq_t               asm_eq [`NUM_COLS];
    wire rx_cell_t     cur_cell = rx_buf[rx_rd_r][rx_col_r];
    wire               cur_skip = !cur_cell.vld || cur_cell.start;
    wire               cur_send = cur_cell.vld && !cur_cell.start && !out_busy;
    wire               cur_step = lock_r && (cur_skip || cur_send);

    assign out_busy = (out_req_r != out_ack_s);

    always_comb begin
        for (int j = 0; j < `NUM_COLS; j++) begin
            asm_eq[j].ctrl = {rxc_i[j], lo_c_r[j]};
            asm_eq[j].data = {rxd_i[j], lo_d_r[j]};
        end
    end

    always_ff @(posedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_rd_r       <= '0;
            rx_col_r      <= '0;
            lock_r        <= 1'b0;
            out_req_r     <= 1'b0;
            out_item_r    <= '0;
            delay_fault_o <= 1'b0;
            for (int j = 0; j < `NUM_COLS; j++) begin
                rx_st_r[j]  <= RX_HUNT;
                lo_d_r[j]   <= '0;
                lo_c_r[j]   <= '0;
                rx_wr_r[j]  <= '0;
                rx_rem_r[j] <= '0;
                rx_mac_r[j] <= '0;
                for (int r = 0; r < `NUM_ROWS; r++) begin
                    rx_buf[r][j].vld <= 1'b0;
                end
            end
        end else begin
            // readout first so that a write to the same cell wins
            if (cur_step) begin
                rx_buf[rx_rd_r][rx_col_r].vld <= 1'b0;
                if (cur_send) begin
                    out_item_r <= '{mac: cur_cell.mac, cont_hdr: cur_cell.cont, eq: cur_cell.eq};
                    out_req_r  <= !out_req_r;
                end
                rx_col_r <= rx_col_r + 1'b1;
                if (rx_col_r == `COL_LAST) begin
                    rx_rd_r <= rx_rd_r + 1'b1;
                end
            end
            for (int j = 0; j < `NUM_COLS; j++) begin
                case (rx_st_r[j])
                    RX_HUNT: begin
                        lo_d_r[j] <= rxd_i[j];
                        lo_c_r[j] <= rxc_i[j];
                        if (col_en[j] && rxc_i[j][0] &&
                            rxd_i[j][`HDR_START_MSB:`HDR_START_LSB] == `START_CODE) begin
                            rx_st_r[j] <= RX_HDR2;
                        end
                    end
                    RX_HDR2: begin
                        // header lands at the row its marker names
                        rx_buf[asm_eq[j].data[`HDR_ROW_MSB:`HDR_ROW_LSB]][j] <= '{
                            vld: 1'b1, start: asm_eq[j].data[`HDR_SF_BIT],
                            cont: !asm_eq[j].data[`HDR_SF_BIT],
                            mac: asm_eq[j].data[`HDR_LOGICAL_LINK_IDENTIFIER_LSB +: `MAC_W] & mac_mask,
                            eq: asm_eq[j]};
                        rx_wr_r[j]  <= asm_eq[j].data[`HDR_ROW_MSB:`HDR_ROW_LSB] + 1'b1;
                        rx_rem_r[j] <= asm_eq[j].data[`HDR_LEN_MSB:`HDR_LEN_LSB] - 1'b1;
                        rx_mac_r[j] <= asm_eq[j].data[`HDR_LOGICAL_LINK_IDENTIFIER_LSB +: `MAC_W] & mac_mask;
                        rx_st_r[j]  <= (asm_eq[j].data[`HDR_LEN_MSB:`HDR_LEN_LSB] > 16'h0001)
                                       ? RX_BODY1 : RX_HUNT;
                        if (!lock_r) begin
                            lock_r   <= 1'b1;
                            rx_rd_r  <= asm_eq[j].data[`HDR_ROW_MSB:`HDR_ROW_LSB] - `RX_LAG;
                            rx_col_r <= '0;
                        end else if (asm_eq[j].data[`HDR_ROW_MSB:`HDR_ROW_LSB] - rx_rd_r
                                     > `DELAY_BOUND_EQ) begin
                            delay_fault_o <= 1'b1;
                        end
                    end
                    RX_BODY1: begin
                        lo_d_r[j]  <= rxd_i[j];
                        lo_c_r[j]  <= rxc_i[j];
                        rx_st_r[j] <= RX_BODY2;
                    end
                    RX_BODY2: begin
                        // idle rows inside an open envelope keep their row but carry nothing
                        rx_wr_r[j] <= rx_wr_r[j] + 1'b1;
                        rx_st_r[j] <= RX_BODY1;
                        if (asm_eq[j].ctrl != `IDLE_CTRL) begin
                            rx_buf[rx_wr_r[j]][j] <= '{vld: 1'b1, start: 1'b0, cont: 1'b0,
                                                       mac: rx_mac_r[j], eq: asm_eq[j]};
                            rx_rem_r[j] <= rx_rem_r[j] - 1'b1;
                            rx_st_r[j]  <= (rx_rem_r[j] == 16'h0001) ? RX_HUNT : RX_BODY1;
                        end
                    end
                    default: begin
                        rx_st_r[j] <= RX_HUNT;
                    end
                endcase
            end
        end
    end

endmodule // bonding_deskew

// File: tb/bonding_deskew_sva.sv
// Purpose: port checks on the bonded channel deskew block
// Assumes: bound onto bonding_deskew, sees only its ports
// Notes:   link checks look at the low and high halves of header transfers
`timescale 1ns/10ps
`include "bonding_deskew_params.svh"

module bonding_deskew_sva
    import bonding_deskew_pkg::*;
(
    // clocks and reset
    input  wire logic                    core_clk_i,
    input  wire logic                    link_clk_i,
    input  wire logic                    rst_i,
    // mac side
    input  wire logic                    tx_valid_i,
    input  wire logic                    tx_ready_o,
    input  wire logic                    rx_valid_o,
    input  wire rx_item_t                rx_item_o,
    // link side
    input  wire logic [`XFER_DATA_W-1:0] txd_o [`NUM_COLS],
    input  wire logic [`XFER_CTRL_W-1:0] txc_o [`NUM_COLS]
);
    a_ready_take_drop: assert property (@(posedge core_clk_i) disable iff (rst_i)
        tx_valid_i && tx_ready_o |=> !tx_ready_o [*4])
        else $error("ready did not drop after a take");
    a_rx_pulse_gap: assert property (@(posedge core_clk_i) disable iff (rst_i)
        rx_valid_o |=> !rx_valid_o [*4])
        else $error("receive valid not a single pulse");
    a_rx_item_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !rx_valid_o |-> $stable(rx_item_o))
        else $error("receive item changed without valid");
    a_no_start_deliv: assert property (@(posedge core_clk_i) disable iff (rst_i)
        rx_valid_o && rx_item_o.eq.ctrl[0] && rx_item_o.eq.data[7:0] == `START_CODE |-> !rx_item_o.eq.data[8])
        else $error("start header delivered to mac side");
    a_hdr_flag_col0: assert property (@(posedge link_clk_i) disable iff (rst_i)
        txc_o[0][0] && txd_o[0][7:0] == `START_CODE |-> txd_o[0][8])
        else $error("column 0 header without start flag");
    a_hdr_flag_col1: assert property (@(posedge link_clk_i) disable iff (rst_i)
        txc_o[1][0] && txd_o[1][7:0] == `START_CODE |-> txd_o[1][8])
        else $error("column 1 header without start flag");
    a_hdr_pair_col2: assert property (@(posedge link_clk_i) disable iff (rst_i)
        txc_o[2][0] && txd_o[2][7:0] == `START_CODE |=> txc_o[2] == 4'h0)
        else $error("column 2 header high half wrong control");
    a_hdr_pair_col3: assert property (@(posedge link_clk_i) disable iff (rst_i)
        txc_o[3][0] && txd_o[3][7:0] == `START_CODE |=> txc_o[3] == 4'h0)
        else $error("column 3 header high half wrong control");
endmodule // bonding_deskew_sva

// File: tb/link_loopback.sv
// Purpose: far side lanes, loops each transmit column back with its own skew
// Assumes: one link clock for all lanes
// Notes:   sends idle until enabled, so start-up garbage never reaches receive
`timescale 1ns/10ps
`include "bonding_deskew_params.svh"

module link_loopback (
    // clock and control
    input  wire logic                    link_clk_i,
    input  wire logic                    en_i,
    // lanes from the block
    input  wire logic [`XFER_DATA_W-1:0] txd_i [`NUM_COLS],
    input  wire logic [`XFER_CTRL_W-1:0] txc_i [`NUM_COLS],
    // lanes into the block
    output logic      [`XFER_DATA_W-1:0] rxd_o [`NUM_COLS],
    output logic      [`XFER_CTRL_W-1:0] rxc_o [`NUM_COLS]
);
    localparam int SKEW [`NUM_COLS] = '{1, 6, 3, 8};
    logic [35:0] line_r [`NUM_COLS][9];

    always_ff @(posedge link_clk_i) begin
        for (int c = 0; c < `NUM_COLS; c++) begin
            line_r[c][0] <= {txc_i[c], txd_i[c]};
            for (int k = 1; k < 9; k++) begin
                line_r[c][k] <= line_r[c][k-1];
            end
        end
    end

    // unequal lane delays, transfer pairs kept whole and gap free
    always_comb begin
        for (int c = 0; c < `NUM_COLS; c++) begin
            {rxc_o[c], rxd_o[c]} = en_i ? line_r[c][SKEW[c]] : {4'hF, 32'h07070707};
        end
    end
endmodule // link_loopback

// File: tb/bonding_deskew_tb.sv
// Purpose: self-checking bench for the bonded channel deskew block
// Assumes: four channels and four macs, then one channel and two macs, lanes looped back with skew
// Notes:   rows hold items sent and the receive items they should give
`timescale 1ns/10ps
`include "bonding_deskew_params.svh"

module bonding_deskew_tb
    import bonding_deskew_pkg::*;
;
    typedef struct packed {
        tx_item_t   it;
        logic       want;
        logic [1:0] mac;
    } row_t;
    localparam int LIMIT = 60000;
    logic                    core_clk = 1'b0;
    logic                    link_clk = 1'b0;
    logic                    rst;
    logic                    link_en;
    logic [1:0]              cfg_ch_mode;
    logic [1:0]              cfg_mac_mode;
    logic                    tx_valid;
    tx_item_t                tx_item;
    logic                    tx_ready;
    logic                    rx_valid;
    rx_item_t                rx_item;
    logic [`XFER_DATA_W-1:0] txd [`NUM_COLS];
    logic [`XFER_CTRL_W-1:0] txc [`NUM_COLS];
    logic [`XFER_DATA_W-1:0] rxd [`NUM_COLS];
    logic [`XFER_CTRL_W-1:0] rxc [`NUM_COLS];
    logic                    delay_fault;
    row_t                    rows [10];
    rx_item_t                got [$];
    rx_item_t                exp_q [$];
    int                      miscompares = 0;
    int                      n_tests = 0;
    int                      cyc = 0;

    always #2.5 core_clk = ~core_clk;
    initial begin
        #7.3;
        forever #62.5 link_clk = ~link_clk;
    end

    bonding_deskew DUT (.core_clk_i(core_clk), .link_clk_i(link_clk), .rst_i(rst), .cfg_ch_mode_i(cfg_ch_mode),
        .cfg_mac_mode_i(cfg_mac_mode), .tx_valid_i(tx_valid), .tx_item_i(tx_item), .tx_ready_o(tx_ready),
        .rx_valid_o(rx_valid), .rx_item_o(rx_item), .txd_o(txd), .txc_o(txc), .rxd_i(rxd), .rxc_i(rxc),
        .delay_fault_o(delay_fault));
    link_loopback u_far (.link_clk_i(link_clk), .en_i(link_en), .txd_i(txd), .txc_i(txc), .rxd_o(rxd), .rxc_o(rxc));

    task automatic check(input string name, input logic [74:0] seen, input logic [74:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic send(input tx_item_t it);
        int w;
        w = 0;
        while (tx_ready !== 1'b1 && w < 5000) begin
            @(negedge core_clk);
            w++;
        end
        tx_valid = 1'b1;
        tx_item = it;
        @(negedge core_clk);
        tx_valid = 1'b0;
    endtask

    function automatic row_t mk(bit env, logic [1:0] ch, logic [15:0] id, logic [15:0] len, logic [63:0] d);
        mk.it = '{is_env: env, ch: ch, logical_link_identifier: id, len: len, eq: '{ctrl: `DATA_CTRL, data: d}};
        mk.want = !env;
        mk.mac = id[1:0];
    endfunction

    always @(negedge core_clk) begin
        if (rx_valid === 1'b1) begin
            got.push_back(rx_item);
        end
    end

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            miscompares++;
            summarize();
        end
    end

    initial begin
        rst = 1'b1;
        link_en = 1'b0;
        cfg_ch_mode = 2'h2;
        cfg_mac_mode = 2'h2;
        tx_valid = 1'b0;
        tx_item = '0;
        // two bonded envelopes for one link, two single ones for others
        rows = '{mk(1, 2'h0, 16'h0001, 16'h0003, 64'h0), mk(1, 2'h1, 16'h0001, 16'h0003, 64'h0),
                 mk(1, 2'h2, 16'h0002, 16'h0002, 64'h0), mk(1, 2'h3, 16'h0003, 16'h0002, 64'h0),
                 mk(0, 2'h0, 16'h0001, 16'h0000, 64'hA1A1_0000_0000_0010),
                 mk(0, 2'h0, 16'h0001, 16'h0000, 64'hA2A2_0000_0000_0020),
                 mk(0, 2'h0, 16'h0001, 16'h0000, 64'hA3A3_0000_0000_0030),
                 mk(0, 2'h0, 16'h0001, 16'h0000, 64'hA4A4_0000_0000_0040),
                 mk(0, 2'h0, 16'h0002, 16'h0000, 64'hB5B5_0000_0000_0050),
                 mk(0, 2'h0, 16'h0003, 16'h0000, 64'hC6C6_0000_0000_0060)};
        repeat (4) @(negedge link_clk);
        check("ready_in_reset", 75'(tx_ready), 75'h0);
        check("rx_valid_in_reset", 75'(rx_valid), 75'h0);
        check("txd0_in_reset", 75'(txd[0]), 75'h0);
        @(negedge core_clk);
        rst = 1'b0;
        $display("test reset done");
        repeat (80) @(negedge link_clk);
        link_en = 1'b1;
        @(negedge core_clk);
        foreach (rows[i]) begin
            send(rows[i].it);
            if (rows[i].want) begin
                exp_q.push_back('{mac: rows[i].mac, cont_hdr: 1'b0, eq: rows[i].it.eq});
            end
        end
        while (got.size() < exp_q.size()) begin
            @(negedge core_clk);
        end
        foreach (exp_q[i]) begin
            check("rx_item", got[i], exp_q[i]);
        end
        repeat (2000) @(negedge core_clk);
        check("rx_count", 75'(got.size()), 75'(exp_q.size()));
        check("delay_fault", 75'(delay_fault), 75'h0);
        $display("test bonding done");
        // reset in mid-run, then one channel and two macs
        rst = 1'b1;
        cfg_ch_mode = 2'h0;
        cfg_mac_mode = 2'h1;
        repeat (4) @(negedge link_clk);
        check("fault_in_reset", 75'(delay_fault), 75'h0);
        @(negedge core_clk);
        rst = 1'b0;
        repeat (80) @(negedge link_clk);
        @(negedge core_clk);
        got.delete();
        rows[0] = mk(1, 2'h0, 16'h0003, 16'h0002, 64'h0);
        rows[1] = mk(0, 2'h0, 16'h0003, 16'h0000, 64'hD7D7_0000_0000_0070);
        send(rows[0].it);
        send(rows[1].it);
        while (got.size() < 1) begin
            @(negedge core_clk);
        end
        check("one_ch_item", got[0], {2'h1, 1'b0, `DATA_CTRL, 64'hD7D7_0000_0000_0070});
        repeat (2000) @(negedge core_clk);
        check("one_ch_count", 75'(got.size()), 75'h1);
        $display("test single channel done");
        summarize();
    end
endmodule // bonding_deskew_tb

bind bonding_deskew bonding_deskew_sva u_sva (.core_clk_i(core_clk_i), .link_clk_i(link_clk_i), .rst_i(rst_i),
    .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o), .rx_valid_o(rx_valid_o), .rx_item_o(rx_item_o),
    .txd_o(txd_o), .txc_o(txc_o));
